// ===== dve_coef_if.sv
// Request/answer bundle between the register bank and the coefficient RAM
`timescale 1ns/100ps
interface dve_coef_if;
    import dve_pkg::*;
    logic req_write;
    logic req_fetch;
    logic [IDX_W-1:0] index;
    logic [COEF_W-1:0] wdata;
    logic idle;
    logic wr_done;
    logic [COEF_W-1:0] rdata;

    modport ctrl(output req_write, output req_fetch, output index,
                 output wdata, input idle, input wr_done, input rdata);
    modport ram(input req_write, input req_fetch, input index,
                input wdata, output idle, output wr_done, output rdata);
endinterface

// ===== dve_coef_ram.sv
// Coefficient RAM with its write/fetch sequencer and datapath read port
`timescale 1ns/100ps
module dve_coef_ram (
    input wire logic clk_i,
    input wire logic nrst_i,
    dve_coef_if.ram cif,
    input wire logic [dve_pkg::IDX_W-1:0] dp_addr_i,
    output logic [dve_pkg::COEF_W-1:0] dp_data_o
);
    import dve_pkg::*;

    dve_seq_e state_q, state_d;
    logic [COEF_W-1:0] wdata_q, wdata_d;
    logic [COEF_W-1:0] rdata_q, rdata_d;
    logic [COEF_W-1:0] dp_data_q, dp_data_d;
    logic [COEF_W-1:0] mem_q [COEF_DEPTH];
    logic [COEF_W-1:0] mem_d [COEF_DEPTH];

    // Words past the populated depth read as zero
    function automatic logic [COEF_W-1:0] rd_word(input logic [IDX_W-1:0] a);
        logic [COEF_W-1:0] w;
        w = '0;
        if (int'(a) < COEF_DEPTH) begin
            w = mem_q[a];
        end
        return w;
    endfunction

    // Sequencer: write one cycle, then fetch the next location
    always_comb begin
        state_d = state_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        mem_d = mem_q;
        dp_data_d = rd_word(dp_addr_i);
        unique case (state_q)
            DVE_IDLE: begin
                if (cif.req_write) begin
                    wdata_d = cif.wdata;
                    state_d = DVE_WRITE;
                end else if (cif.req_fetch) begin
                    state_d = DVE_FETCH;
                end
            end
            DVE_WRITE: begin
                if (int'(cif.index) < COEF_DEPTH) begin
                    mem_d[cif.index] = wdata_q;
                end
                state_d = DVE_FETCH;
            end
            DVE_FETCH: begin
                rdata_d = rd_word(cif.index);
                state_d = DVE_IDLE;
            end
            default: begin
                state_d = DVE_IDLE;
            end
        endcase
    end

    // Control state registers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_q <= DVE_IDLE;
            wdata_q <= '0;
            rdata_q <= '0;
            dp_data_q <= '0;
        end else begin
            state_q <= state_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            dp_data_q <= dp_data_d;
        end
    end

    // Storage array, not reset
    always_ff @(posedge clk_i) begin
        mem_q <= mem_d;
    end

    // Status back to the register bank
    assign cif.idle = (state_q == DVE_IDLE);
    assign cif.wr_done = (state_q == DVE_WRITE);
    assign cif.rdata = rdata_q;
    assign dp_data_o = dp_data_q;
endmodule

// ===== dve_host_model.sv
// Host controller model issuing byte register writes and reads
`timescale 1ns/100ps
module dve_host_model
    import dve_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    // Idle levels at time zero
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // One-cycle write strobe; released lines show the inverse value
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
    endtask

    // One-cycle read strobe; data taken once registered
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask

    // Poll the status register until no RAM access runs, bounded
    task automatic wait_idle(output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int n = 0; n < 16 && !ok; n++) begin
            rd_reg(ADDR_STATUS, s);
            ok = (s[BIT_BUSY] === 1'b0);
        end
    endtask
endmodule

// ===== dve_pkg.sv
// Constants, register map and sequencer states of the volume/EQ control block
package dve_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned COEF_W = 24;
    localparam int unsigned COEF_DEPTH = 161;
    localparam int unsigned BE_W = 3;

    // Register offsets on the control bus
    localparam logic [7:0] ADDR_LEFT_VOL = 8'h04;
    localparam logic [7:0] ADDR_RIGHT_VOL = 8'h05;
    localparam logic [7:0] ADDR_VOL_UPDATE = 8'h0a;
    localparam logic [7:0] ADDR_EQ_CFG = 8'h20;
    localparam logic [7:0] ADDR_WR_LO = 8'h3a;
    localparam logic [7:0] ADDR_WR_MID = 8'h3b;
    localparam logic [7:0] ADDR_WR_HI = 8'h3c;
    localparam logic [7:0] ADDR_RD_LO = 8'h3d;
    localparam logic [7:0] ADDR_RD_MID = 8'h3e;
    localparam logic [7:0] ADDR_RD_HI = 8'h3f;
    localparam logic [7:0] ADDR_WORD_INDEX = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'h8a;

    // Reset values and masks
    localparam logic [7:0] RST_VOL = 8'hff;
    localparam logic [7:0] RST_VOL_UPDATE = 8'hc0;
    localparam logic [7:0] RST_EQ_CFG = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] VOL_UPDATE_WMASK = 8'hc7;
    localparam logic [7:0] VOL_MUTE_CODE = 8'h00;
    localparam logic [7:0] VOL_FULL_CODE = 8'hff;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [IDX_W-1:0] IDX_STEP = 8'h01;

    // Field positions
    localparam int unsigned BIT_SIMUL_UPDATE = 2;
    localparam int unsigned BIT_SECOND_EN = 7;
    localparam int unsigned SECOND_BE_LSB = 4;
    localparam int unsigned BIT_FIRST_EN = 3;
    localparam int unsigned FIRST_BE_LSB = 0;
    localparam int unsigned BIT_BUSY = 7;
    localparam logic [BE_W-1:0] BE_RESERVED = 3'h7;
    localparam logic [BE_W-1:0] BE_ALL_BANDS = 3'h6;
    localparam logic [BE_W-1:0] BE_NONE = 3'h0;

    // Coefficient access sequencer
    typedef enum logic [1:0] {
        DVE_IDLE = 2'b00,
        DVE_WRITE = 2'b01,
        DVE_FETCH = 2'b11
    } dve_seq_e;
endpackage

// ===== dve_regs.sv
// Volume, equalizer enable and coefficient access register bank
`timescale 1ns/100ps
module dve_regs (
    input wire logic clk_i,
    input wire logic nrst_i,
    // Byte register port from the control-bus slave
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [dve_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [dve_pkg::DATA_W-1:0] reg_rdata_o,
    // Volume controls to the audio path
    output logic [dve_pkg::DATA_W-1:0] left_volume_code_o,
    output logic [dve_pkg::DATA_W-1:0] right_volume_code_o,
    output logic left_mute_o,
    output logic right_mute_o,
    output logic [dve_pkg::DATA_W-1:0] left_atten_steps_o,
    output logic [dve_pkg::DATA_W-1:0] right_atten_steps_o,
    // Equalizer bank controls
    output logic first_bank_enable_o,
    output logic first_bank_prescale_o,
    output logic [dve_pkg::BE_W-1:0] first_bank_band_count_o,
    output logic second_bank_enable_o,
    output logic second_bank_prescale_o,
    output logic [dve_pkg::BE_W-1:0] second_bank_band_count_o,
    // Coefficient read port for the filter datapath
    input wire logic [dve_pkg::IDX_W-1:0] coef_dp_addr_i,
    output logic [dve_pkg::COEF_W-1:0] coef_dp_data_o,
    // Access in progress
    output logic coef_access_busy_o
);
    import dve_pkg::*;

    // Bundle to the sequencer; one write or fetch runs at a time
    dve_coef_if cif ();

    // Host-visible registers
    // left_reg_q holds a left write; left_volume_code_q is applied
    logic [DATA_W-1:0] left_reg_q, left_reg_d;
    logic [DATA_W-1:0] right_volume_code_q, right_volume_code_d;
    logic [DATA_W-1:0] left_volume_code_q, left_volume_code_d;
    logic [DATA_W-1:0] vol_update_q, vol_update_d;
    logic [DATA_W-1:0] eq_cfg_q, eq_cfg_d;
    logic [DATA_W-1:0] wr_lo_q, wr_lo_d;
    logic [DATA_W-1:0] wr_mid_q, wr_mid_d;
    logic [DATA_W-1:0] wr_hi_q, wr_hi_d;
    logic [IDX_W-1:0] coef_word_index_q, coef_word_index_d;
    // Queues a fetch until the sequencer is idle
    logic fetch_pend_q, fetch_pend_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;

    // Derived output registers
    // Each follows its setting one cycle later
    logic left_mute_q, left_mute_d;
    logic right_mute_q, right_mute_d;
    logic [DATA_W-1:0] left_atten_q, left_atten_d;
    logic [DATA_W-1:0] right_atten_q, right_atten_d;
    logic [BE_W-1:0] first_bands_q, first_bands_d;
    logic [BE_W-1:0] second_bands_q, second_bands_d;

    // Decoded strobes and register fields
    // Launch and busy are combinational for an early poll
    logic launch;
    logic busy;
    logic simul_update;
    logic [BE_W-1:0] first_be;
    logic [BE_W-1:0] second_be;
    logic [COEF_W-1:0] coef_read_word;

    // Field views of the control registers
    // Reserved band values are mapped further down
    assign simul_update = vol_update_q[BIT_SIMUL_UPDATE];
    assign first_be = eq_cfg_q[FIRST_BE_LSB +: BE_W];
    assign second_be = eq_cfg_q[SECOND_BE_LSB +: BE_W];
    assign coef_read_word = cif.rdata;

    // Busy covers a running access and a fetch still waiting to start
    // so a poll never sees idle ahead of a stale read word
    assign busy = !cif.idle || fetch_pend_q;

    // High byte write starts a RAM write only when the sequencer is free
    // A high byte taken while the sequencer runs is stored but starts nothing
    assign launch = reg_wr_i && (reg_addr_i == ADDR_WR_HI) && cif.idle;

    // Requests to the coefficient RAM
    // The high byte comes straight from the bus with the launch
    // Write wins over a queued fetch in the sequencer
    assign cif.req_write = launch;
    assign cif.req_fetch = fetch_pend_q;
    assign cif.index = coef_word_index_q;
    assign cif.wdata = {reg_wdata_i, wr_mid_q, wr_lo_q};

    // Register writes, index stepping and fetch requests
    always_comb begin
        left_reg_d = left_reg_q;
        right_volume_code_d = right_volume_code_q;
        left_volume_code_d = left_volume_code_q;
        vol_update_d = vol_update_q;
        eq_cfg_d = eq_cfg_q;
        wr_lo_d = wr_lo_q;
        wr_mid_d = wr_mid_q;
        wr_hi_d = wr_hi_q;
        coef_word_index_d = coef_word_index_q;
        fetch_pend_d = fetch_pend_q;
        // A pending fetch is taken, or superseded by a write, once idle
        // Cleared first so a write below can set it again
        if (cif.idle) begin
            fetch_pend_d = 1'b0;
        end
        // Host writes; a held left value waits in left_reg_q
        // Read-only offsets fall to the default branch
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_LEFT_VOL: begin
                    left_reg_d = reg_wdata_i;
                    if (!simul_update) begin
                        left_volume_code_d = reg_wdata_i;
                    end
                end
                // Right write also releases the held left value
                ADDR_RIGHT_VOL: begin
                    right_volume_code_d = reg_wdata_i;
                    left_volume_code_d = left_reg_q;
                end
                ADDR_VOL_UPDATE: begin
                    // Bits 5:3 stay zero
                    vol_update_d = reg_wdata_i & VOL_UPDATE_WMASK;
                end
                ADDR_EQ_CFG: begin
                    eq_cfg_d = reg_wdata_i;
                end
                ADDR_WR_LO: begin
                    wr_lo_d = reg_wdata_i;
                end
                ADDR_WR_MID: begin
                    wr_mid_d = reg_wdata_i;
                end
                ADDR_WR_HI: begin
                    wr_hi_d = reg_wdata_i;
                end
                ADDR_WORD_INDEX: begin
                    // A new index prefetches its word
                    coef_word_index_d = reg_wdata_i;
                    fetch_pend_d = 1'b1;
                end
                default: begin
                    // Read-only and unmapped offsets take no write
                    fetch_pend_d = fetch_pend_d;
                end
            endcase
        end
        // Reading the high byte steps to and prefetches the next word
        if (reg_rd_i && (reg_addr_i == ADDR_RD_HI)) begin
            coef_word_index_d = coef_word_index_q + IDX_STEP;
            fetch_pend_d = 1'b1;
        end
        // Completed RAM write steps the index before its fetch
        // A high byte read in the same cycle steps only once
        if (cif.wr_done) begin
            coef_word_index_d = coef_word_index_q + IDX_STEP;
        end
    end

    // Read data captured on the read strobe
    always_comb begin
        rdata_d = rdata_q;
        // Unmapped offsets read zero; data stands until the next read
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_LEFT_VOL: rdata_d = left_reg_q;
                ADDR_RIGHT_VOL: rdata_d = right_volume_code_q;
                ADDR_VOL_UPDATE: rdata_d = vol_update_q;
                ADDR_EQ_CFG: rdata_d = eq_cfg_q;
                ADDR_WR_LO: rdata_d = wr_lo_q;
                ADDR_WR_MID: rdata_d = wr_mid_q;
                ADDR_WR_HI: rdata_d = wr_hi_q;
                // Read bytes show the last fetched word
                ADDR_RD_LO: rdata_d = coef_read_word[7:0];
                ADDR_RD_MID: rdata_d = coef_read_word[15:8];
                ADDR_RD_HI: rdata_d = coef_read_word[23:16];
                ADDR_WORD_INDEX: rdata_d = coef_word_index_q;
                // Only the busy bit is defined
                ADDR_STATUS: begin
                    rdata_d = READ_ZERO;
                    rdata_d[BIT_BUSY] = busy;
                end
                default: rdata_d = READ_ZERO;
            endcase
        end
    end

    // Volume and equalizer controls for the audio path
    always_comb begin
        // Code zero mutes; otherwise steps of 0.375dB below full scale
        // Mute and attenuation trail the applied code by one cycle
        // Attenuation counts 0.375dB steps below 0dB
        left_mute_d = (left_volume_code_q == VOL_MUTE_CODE);
        right_mute_d = (right_volume_code_q == VOL_MUTE_CODE);
        left_atten_d = VOL_FULL_CODE - left_volume_code_q;
        right_atten_d = VOL_FULL_CODE - right_volume_code_q;
        // Reserved band value runs all six bands; bypassed bank runs none
        first_bands_d = BE_NONE;
        second_bands_d = BE_NONE;
        if (eq_cfg_q[BIT_FIRST_EN]) begin
            first_bands_d = (first_be == BE_RESERVED) ?
                BE_ALL_BANDS : first_be;
        end
        if (eq_cfg_q[BIT_SECOND_EN]) begin
            second_bands_d = (second_be == BE_RESERVED) ?
                BE_ALL_BANDS : second_be;
        end
    end

    // Register stage for all state above
    // All state resets synchronously, active low
    // The RAM array is not in here and keeps its data over reset
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            left_reg_q <= RST_VOL;
            right_volume_code_q <= RST_VOL;
            left_volume_code_q <= RST_VOL;
            vol_update_q <= RST_VOL_UPDATE;
            eq_cfg_q <= RST_EQ_CFG;
            wr_lo_q <= RST_BYTE;
            wr_mid_q <= RST_BYTE;
            wr_hi_q <= RST_BYTE;
            coef_word_index_q <= RST_BYTE;
            fetch_pend_q <= 1'b0;
            rdata_q <= RST_BYTE;
            left_mute_q <= 1'b0;
            right_mute_q <= 1'b0;
            left_atten_q <= RST_BYTE;
            right_atten_q <= RST_BYTE;
            first_bands_q <= BE_NONE;
            second_bands_q <= BE_NONE;
        end else begin
            left_reg_q <= left_reg_d;
            right_volume_code_q <= right_volume_code_d;
            left_volume_code_q <= left_volume_code_d;
            vol_update_q <= vol_update_d;
            eq_cfg_q <= eq_cfg_d;
            wr_lo_q <= wr_lo_d;
            wr_mid_q <= wr_mid_d;
            wr_hi_q <= wr_hi_d;
            coef_word_index_q <= coef_word_index_d;
            fetch_pend_q <= fetch_pend_d;
            rdata_q <= rdata_d;
            left_mute_q <= left_mute_d;
            right_mute_q <= right_mute_d;
            left_atten_q <= left_atten_d;
            right_atten_q <= right_atten_d;
            first_bands_q <= first_bands_d;
            second_bands_q <= second_bands_d;
        end
    end

    // Coefficient storage and its access sequencer
    // Its datapath port reads apart from the host port
    // Reset is shared so both halves leave it together
    dve_coef_ram u_coef_ram (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .cif(cif.ram),
        .dp_addr_i(coef_dp_addr_i),
        .dp_data_o(coef_dp_data_o)
    );

    // Outputs
    // Enables come straight from the configuration register
    assign reg_rdata_o = rdata_q;
    assign left_volume_code_o = left_volume_code_q;
    assign right_volume_code_o = right_volume_code_q;
    assign left_mute_o = left_mute_q;
    assign right_mute_o = right_mute_q;
    assign left_atten_steps_o = left_atten_q;
    assign right_atten_steps_o = right_atten_q;
    assign first_bank_enable_o = eq_cfg_q[BIT_FIRST_EN];
    assign second_bank_enable_o = eq_cfg_q[BIT_SECOND_EN];
    // Prescaler runs whenever its bank is in the path
    assign first_bank_prescale_o = eq_cfg_q[BIT_FIRST_EN];
    assign second_bank_prescale_o = eq_cfg_q[BIT_SECOND_EN];
    // Band counts are registered, one cycle behind the enables
    assign first_bank_band_count_o = first_bands_q;
    assign second_bank_band_count_o = second_bands_q;
    assign coef_access_busy_o = busy;
endmodule

// ===== dve_regs_properties.sv
// Concurrent checks on the volume, equalizer and coefficient register bank
`timescale 1ns/100ps
module dve_regs_properties
    import dve_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] left_volume_code_o,
    input wire logic [7:0] right_volume_code_o,
    input wire logic left_mute_o,
    input wire logic first_bank_enable_o,
    input wire logic first_bank_prescale_o,
    input wire logic [2:0] first_bank_band_count_o,
    input wire logic second_bank_enable_o,
    input wire logic [2:0] second_bank_band_count_o,
    input wire logic coef_access_busy_o
);
    // Decoded volume writes, used as causes of code changes
    wire logic wr_left = reg_wr_i && reg_addr_i == ADDR_LEFT_VOL;
    wire logic wr_right = reg_wr_i && reg_addr_i == ADDR_RIGHT_VOL;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // A RAM access holds busy for two cycles, then drops it
    sequence seq_access;
        coef_access_busy_o [*2] ##1 !coef_access_busy_o;
    endsequence

    a_write_launch: assert property (
        reg_wr_i && reg_addr_i == ADDR_WR_HI && !coef_access_busy_o
        |=> seq_access) else $error("high byte write ran no access");
    a_hi_read_fetch: assert property (
        reg_rd_i && reg_addr_i == ADDR_RD_HI && !coef_access_busy_o
        |=> seq_access) else $error("high byte read ran no fetch");
    a_index_fetch: assert property (
        reg_wr_i && reg_addr_i == ADDR_WORD_INDEX && !coef_access_busy_o
        |=> seq_access) else $error("index write ran no fetch");
    a_busy_clears: assert property (
        $rose(coef_access_busy_o) |-> ##[1:4] !coef_access_busy_o)
        else $error("busy flag stuck high");
    a_status_view: assert property (
        reg_rd_i && reg_addr_i == ADDR_STATUS |=>
        reg_rdata_o == {$past(coef_access_busy_o), 7'h00})
        else $error("status read does not show busy");
    a_status_ro: assert property (
        reg_wr_i && reg_addr_i == ADDR_STATUS && !coef_access_busy_o
        |=> !coef_access_busy_o) else $error("status write started access");
    a_mute_code: assert property (
        left_mute_o == ($past(left_volume_code_o) == VOL_MUTE_CODE))
        else $error("left mute does not follow code zero");
    a_right_vol_cause: assert property (
        $changed(right_volume_code_o) |-> $past(wr_right) || $past(wr_right, 2))
        else $error("right volume changed without a write");
    a_left_vol_cause: assert property (
        $changed(left_volume_code_o) |-> $past(wr_left) || $past(wr_left, 2)
        || $past(wr_right) || $past(wr_right, 2))
        else $error("left volume changed without a write");
    a_band_bypass: assert property (
        !$past(first_bank_enable_o) && !first_bank_enable_o
        |-> first_bank_band_count_o == BE_NONE)
        else $error("bypassed first bank runs stages");
    a_prescale_on: assert property (
        first_bank_prescale_o == first_bank_enable_o)
        else $error("first prescaler not tied to enable");
    a_no_reserved: assert property (
        first_bank_band_count_o != BE_RESERVED
        && second_bank_band_count_o != BE_RESERVED)
        else $error("reserved band count reached the path");
endmodule

bind dve_regs dve_regs_properties dve_regs_properties_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
    .left_volume_code_o(left_volume_code_o),
    .right_volume_code_o(right_volume_code_o), .left_mute_o(left_mute_o),
    .first_bank_enable_o(first_bank_enable_o),
    .first_bank_prescale_o(first_bank_prescale_o),
    .first_bank_band_count_o(first_bank_band_count_o),
    .second_bank_enable_o(second_bank_enable_o),
    .second_bank_band_count_o(second_bank_band_count_o),
    .coef_access_busy_o(coef_access_busy_o)
);

// ===== tb_top.sv
// Self-checking bench for the volume, equalizer and coefficient registers
`timescale 1ns/100ps
module tb_top;
    import dve_pkg::*;
    logic clk, nrst, wr, rd, ok;
    logic [7:0] addr, wdata, rdata, lv, rv, la, d, dp_addr, rat;
    logic lm, rm, e1, p1, e2, p2, busy;
    logic [2:0] c1, c2;
    logic [23:0] dp_data;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] ra [12] = '{8'h04, 8'h05, 8'h0a, 8'h20, 8'h3a, 8'h3b,
        8'h3c, 8'h40, 8'h3d, 8'h3e, 8'h3f, 8'h8a};
    logic [7:0] rv0 [12] = '{8'hff, 8'hff, 8'hc0, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    dve_regs dve_regs_i (.clk_i(clk), .nrst_i(nrst), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .left_volume_code_o(lv),
        .right_volume_code_o(rv), .left_mute_o(lm), .right_mute_o(rm),
        .left_atten_steps_o(la), .right_atten_steps_o(rat),
        .first_bank_enable_o(e1), .first_bank_prescale_o(p1),
        .first_bank_band_count_o(c1), .second_bank_enable_o(e2),
        .second_bank_prescale_o(p2), .second_bank_band_count_o(c2),
        .coef_dp_addr_i(dp_addr), .coef_dp_data_o(dp_data),
        .coef_access_busy_o(busy));
    dve_host_model host_i (.clk_i(clk), .rdata_i(rdata), .wr_o(wr),
        .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

    // Compare one value and count it
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Read a register and compare it
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_i.rd_reg(a, d);
        check($sformatf("reg %h", a), d, exp);
    endtask

    // Let registered outputs settle
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Every register reads its reset value
    task automatic t_reset_values;
        for (int i = 0; i < 12; i++) begin
            rd_chk(ra[i], rv0[i]);
        end
        host_i.wr_reg(8'h99, 8'h5a);
        rd_chk(8'h99, READ_ZERO);
    endtask

    // Mute code, immediate left update, held left until right write
    task automatic t_volume;
        host_i.wr_reg(ADDR_LEFT_VOL, 8'h00);
        settle();
        check("left code", lv, 8'h00);
        check("left mute", lm, 1'b1);
        check("right mute", rm, 1'b0);
        host_i.wr_reg(ADDR_VOL_UPDATE, 8'hc4);
        host_i.wr_reg(ADDR_LEFT_VOL, 8'h10);
        settle();
        check("left held", lv, 8'h00);
        rd_chk(ADDR_VOL_UPDATE, 8'hc4);
        host_i.wr_reg(ADDR_RIGHT_VOL, 8'h20);
        settle();
        check("left joint", lv, 8'h10);
        check("right joint", rv, 8'h20);
        check("left atten", la, 8'hef);
        check("right atten", rat, 8'hdf);
        host_i.wr_reg(ADDR_VOL_UPDATE, 8'hc0);
        host_i.wr_reg(ADDR_LEFT_VOL, 8'hfe);
        settle();
        check("left direct", lv, 8'hfe);
        rd_chk(ADDR_RIGHT_VOL, 8'h20);
    endtask

    // All band values on both banks, then differing band values per bank and both banks bypassed
    task automatic t_eq;
        logic [2:0] v;
        for (int i = 0; i < 8; i++) begin
            v = i[2:0];
            host_i.wr_reg(ADDR_EQ_CFG, {1'b1, v, 1'b1, v});
            settle();
            check("bands one", c1, (v == 3'h7) ? 3'h6 : v);
            check("bands two", c2, (v == 3'h7) ? 3'h6 : v);
            check("enables", {e1, p1, e2, p2}, 4'hf);
        end
        host_i.wr_reg(ADDR_EQ_CFG, 8'h8b);
        settle();
        check("mix", {e2, c2, e1, c1}, 8'h8b);
        host_i.wr_reg(ADDR_EQ_CFG, 8'h55);
        settle();
        check("bypass", {e2, c2, e1, c1}, 8'h00);
        rd_chk(ADDR_EQ_CFG, 8'h55);
    endtask

    // Indirect writes, status, auto-increment, prefetch, read-only places
    task automatic t_coef;
        host_i.wr_reg(ADDR_WORD_INDEX, 8'h05);
        host_i.wait_idle(ok);
        host_i.wr_reg(ADDR_WR_LO, 8'hc3);
        host_i.wr_reg(ADDR_WR_MID, 8'hb2);
        host_i.wr_reg(ADDR_WR_HI, 8'ha1);
        check("busy pin", busy, 1'b1);
        rd_chk(ADDR_STATUS, 8'h80);
        host_i.wait_idle(ok);
        check("idle", ok, 1'b1);
        check("busy low", busy, 1'b0);
        rd_chk(ADDR_WORD_INDEX, 8'h06);
        @(posedge clk);
        dp_addr <= 8'h05;
        settle();
        check("ram word", dp_data, 24'ha1b2c3);
        host_i.wr_reg(ADDR_WR_LO, 8'h11);
        host_i.wr_reg(ADDR_WR_MID, 8'h22);
        host_i.wr_reg(ADDR_WR_HI, 8'h33);
        host_i.wait_idle(ok);
        host_i.wr_reg(ADDR_WORD_INDEX, 8'h05);
        host_i.wait_idle(ok);
        rd_chk(ADDR_RD_LO, 8'hc3);
        rd_chk(ADDR_RD_MID, 8'hb2);
        rd_chk(ADDR_RD_HI, 8'ha1);
        host_i.wait_idle(ok);
        host_i.wr_reg(ADDR_RD_LO, 8'h55);
        host_i.wr_reg(ADDR_STATUS, 8'h80);
        rd_chk(ADDR_RD_LO, 8'h11);
        rd_chk(ADDR_STATUS, 8'h00);
        rd_chk(ADDR_RD_MID, 8'h22);
        rd_chk(ADDR_RD_HI, 8'h33);
        host_i.wait_idle(ok);
        rd_chk(ADDR_WORD_INDEX, 8'h07);
        rd_chk(ADDR_WR_HI, 8'h33);
    endtask

    // Print counts and verdict, then stop
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end

    // Reset, then the scenarios in turn
    initial begin
        nrst = 1'b0;
        dp_addr = 8'h00;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_reset_values();
        t_volume();
        t_eq();
        t_coef();
        wrap_up();
    end
endmodule
